/* File: verilog/serial_pin_out_cfg.svh */
// constants for the serial pin output control block
// assumes word-aligned Avalon byte addresses, index*4
`ifndef SERIAL_PIN_OUT_CFG_SVH
`define SERIAL_PIN_OUT_CFG_SVH
// register indices, byte address = index * 4
`define IDX_NFEN   20'hF0060
`define IDX_BUF0   20'hF0128
`define IDX_GATE0  20'hF012A
`define IDX_INV0   20'hF0134
`define IDX_BUF1   20'hF0168
`define IDX_GATE1  20'hF016A
`define IDX_INV1   20'hF0174
`define IDX_ROUTE  20'hFFF3C
`define IDX_RUN0   20'hF0120
`define IDX_GO0    20'hF0122
`define IDX_HALT0  20'hF0124
`define IDX_RUN1   20'hF0160
`define IDX_GO1    20'hF0162
`define IDX_HALT1  20'hF0164
`define IDX_STAT0  20'hF0100
`define IDX_STAT1  20'hF0140
`define STAT_STEP  20'h00002
// reset values and writable/fixed masks
`define SO_RESET   16'h0F0F
`define BUF0_WMASK 16'h0505
`define BUF1_WMASK 16'h0105
`define BUF0_FIX1  16'h0A0A
`define BUF1_FIX1  16'h0E0A
`define GATE_MASK  16'h0005
`define INV_MASK   16'h0005
`define REG16_ZERO 16'h0000
`define NFEN_MASK  8'h55
`define ROUTE_MASK 8'h1F
`define REG8_ZERO  8'h00
`define RX_IDLE    4'hF
`define PIN_IDLE   8'hFF
// bit positions, bit steps and the channel count per unit
`define CLK_OFS    8
`define BIT_XFER   6
`define BIT_BUF    5
`define ROUTE_IRQ  0
`define ROUTE_TIM  1
`define FILT_STEP  2
`define RX_ROUTED  3
`define CH_UNIT    4
`endif

/* File: verilog/serial_pin_pkg.sv */
// types for the serial pin output control block
// assumes a 32-bit Avalon-MM master with waitrequest
package serial_pin_pkg;
   typedef struct packed {
      logic        read;
      logic        write;
      logic [21:0] address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avm_req_type;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } avm_resp_type;
   typedef struct packed {
      logic             waitrequest;
      logic [15:0]      readdata;
      logic [1:0][15:0] so;
      logic [1:0][15:0] gate;
      logic [1:0][15:0] inv;
      logic [7:0]       nfen;
      logic [7:0]       route_sel;
      logic [7:0]       run;
      logic [7:0]       go_trig;
      logic [7:0]       halt_trig;
      logic [7:0]       xfer;
      logic [7:0]       buf_full;
      logic [3:0]       rx_meta;
      logic [3:0]       rx_sync;
      logic [3:0]       rx_prev;
      logic [3:0]       rx_filt;
      logic             irq_meta;
      logic             irq_sync;
      logic             tim_meta;
      logic             tim_sync;
      logic             irq_out;
      logic             tim_out;
      logic [7:0]       data_out;
      logic [7:0]       clk_out;
   } state_type;
endpackage

/* File: verilog/serial_pin_output_control.sv */
// pin output and receive path control, two units of four
// channels; assumes shift engines outside on the same clk
`timescale 1ns/1ps
`include "serial_pin_out_cfg.svh"
module serial_pin_output_control (
   input  logic                         clk,
   input  logic                         rst,
   input  serial_pin_pkg::avm_req_type  avm_req,
   output serial_pin_pkg::avm_resp_type avm_resp,
   input  logic [7:0]                   eng_data_out,
   input  logic [7:0]                   eng_clk_out,
   input  logic [7:0]                   eng_xfer_set,
   input  logic [7:0]                   eng_buf_set,
   input  logic [3:0]                   rx_pin,
   input  logic                         ext_irq0_pin,
   input  logic                         timer_ch7_pin,
   output logic [7:0]                   ser_data_out,
   output logic [7:0]                   ser_clk_out,
   output logic [7:0]                   chan_run_status,
   output logic [7:0]                   xfer_active_flag,
   output logic [7:0]                   buf_full_flag,
   output logic [3:0]                   rx_filtered,
   output logic                         ext_irq0_input,
   output logic                         timer_ch7_input_pin
);
   import serial_pin_pkg::*;

   state_type   s;
   state_type   next;
   logic [19:0] idx;
   logic        wr_take;
   logic        rd_prep;

   ////////////////////////////////////////////////////////////
   // bus decode: one wait cycle, then the access is taken
   assign idx     = avm_req.address[21:2];
   assign wr_take = avm_req.write && !s.waitrequest;
   assign rd_prep = avm_req.read && s.waitrequest;

   // unit-indexed constant pick
   function automatic logic [19:0] pick(input int u,
                                        input logic [19:0] a,
                                        input logic [19:0] b);
      return (u == 0) ? a : b;
   endfunction

   // byte-lane merge limited to bits that may change
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be,
                                         input logic [15:0] allow);
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}} & allow;
      return (old & ~lanes) | (wd[15:0] & lanes);
   endfunction

   ////////////////////////////////////////////////////////////
   // next-state logic for the whole block
   always_comb begin
      int          c;
      logic [15:0] wm;
      logic [15:0] fx;
      logic [15:0] rdv;
      logic [15:0] allow;
      c     = 0;
      wm    = `REG16_ZERO;
      fx    = `REG16_ZERO;
      rdv   = `REG16_ZERO;
      allow = `REG16_ZERO;
      next  = s;
      // wait low for one cycle per request
      next.waitrequest = !((avm_req.read || avm_req.write) && s.waitrequest);

      // triggers: halt has priority over a pending go
      for (int i = 0; i < 8; i++) begin
         if (s.halt_trig[i]) begin
            next.run[i] = 1'h0;
         end else if (s.go_trig[i]) begin
            next.run[i] = 1'h1;
         end
         if (s.halt_trig[i] && !s.run[i]) begin
            next.halt_trig[i] = 1'h0;
         end
         if (s.go_trig[i] && s.run[i]) begin
            next.go_trig[i] = 1'h0;
         end
         if (s.halt_trig[i] || s.go_trig[i]) begin
            next.xfer[i]     = 1'h0;
            next.buf_full[i] = 1'h0;
         end
         // engine set wins over the stop clear
         if (eng_xfer_set[i]) begin
            next.xfer[i] = 1'h1;
         end
         if (eng_buf_set[i]) begin
            next.buf_full[i] = 1'h1;
         end
      end

      // engine owns data bit while gated, clock bit while running
      for (int u = 0; u < 2; u++) begin
         wm = (u == 0) ? `BUF0_WMASK : `BUF1_WMASK;
         fx = (u == 0) ? `BUF0_FIX1 : `BUF1_FIX1;
         for (int n = 0; n < `CH_UNIT; n++) begin
            c = u * `CH_UNIT + n;
            if (s.gate[u][n]) begin
               next.so[u][n] = eng_data_out[c];
            end
            if (s.run[c]) begin
               next.so[u][n + `CLK_OFS] = eng_clk_out[c];
            end
         end
         // fixed bits stay fixed whatever comes in
         next.so[u] = (next.so[u] & wm) | fx;
      end

      // register writes
      if (wr_take) begin
         for (int u = 0; u < 2; u++) begin
            wm = (u == 0) ? `BUF0_WMASK : `BUF1_WMASK;
            allow = wm & ~s.gate[u]
                    & ~{4'h0, s.run[u*`CH_UNIT +: `CH_UNIT], 8'h00};
            if (idx == pick(u, `IDX_BUF0, `IDX_BUF1)) begin
               // ignored bits are left to the engine
               next.so[u] = merge(next.so[u], avm_req.writedata,
                                  avm_req.byteenable, allow);
            end
            if (idx == pick(u, `IDX_GATE0, `IDX_GATE1)) begin
               next.gate[u] = merge(s.gate[u], avm_req.writedata,
                                    avm_req.byteenable, `GATE_MASK);
            end
            if (idx == pick(u, `IDX_INV0, `IDX_INV1)) begin
               next.inv[u] = merge(s.inv[u], avm_req.writedata,
                                   avm_req.byteenable, `INV_MASK);
            end
            if (idx == pick(u, `IDX_GO0, `IDX_GO1) && avm_req.byteenable[0]) begin
               next.go_trig[u*`CH_UNIT +: `CH_UNIT] =
                  s.go_trig[u*`CH_UNIT +: `CH_UNIT]
                  | avm_req.writedata[`CH_UNIT-1:0];
            end
            if (idx == pick(u, `IDX_HALT0, `IDX_HALT1) && avm_req.byteenable[0]) begin
               // writing 0 leaves a pending trigger alone
               next.halt_trig[u*`CH_UNIT +: `CH_UNIT] =
                  next.halt_trig[u*`CH_UNIT +: `CH_UNIT]
                  | avm_req.writedata[`CH_UNIT-1:0];
            end
         end
         if (idx == `IDX_NFEN && avm_req.byteenable[0]) begin
            next.nfen = avm_req.writedata[7:0] & `NFEN_MASK;
         end
         if (idx == `IDX_ROUTE && avm_req.byteenable[0]) begin
            next.route_sel = avm_req.writedata[7:0] & `ROUTE_MASK;
         end
      end

      // read mux, latched one cycle ahead of the answer
      if (rd_prep) begin
         for (int u = 0; u < 2; u++) begin
            if (idx == pick(u, `IDX_BUF0, `IDX_BUF1)) begin
               rdv = s.so[u];
            end
            if (idx == pick(u, `IDX_GATE0, `IDX_GATE1)) begin
               rdv = s.gate[u];
            end
            if (idx == pick(u, `IDX_INV0, `IDX_INV1)) begin
               rdv = s.inv[u];
            end
            if (idx == pick(u, `IDX_RUN0, `IDX_RUN1)) begin
               rdv = {12'h000, s.run[u*`CH_UNIT +: `CH_UNIT]};
            end
            // go and halt addresses fall through to zero
            for (int n = 0; n < `CH_UNIT; n++) begin
               c = u * `CH_UNIT + n;
               if (idx == pick(u, `IDX_STAT0, `IDX_STAT1)
                          + `STAT_STEP * 20'(n)) begin
                  rdv[`BIT_XFER] = s.xfer[c];
                  rdv[`BIT_BUF]  = s.buf_full[c];
               end
            end
         end
         if (idx == `IDX_NFEN) begin
            rdv = {8'h00, s.nfen};
         end
         if (idx == `IDX_ROUTE) begin
            rdv = {8'h00, s.route_sel};
         end
         next.readdata = rdv;
      end

      // pin drive: inversion only behind an open gate
      for (int u = 0; u < 2; u++) begin
         for (int n = 0; n < `CH_UNIT; n++) begin
            c = u * `CH_UNIT + n;
            next.data_out[c] = s.so[u][n]
                               ^ (s.gate[u][n] & s.inv[u][n]);
            next.clk_out[c]  = s.so[u][n + `CLK_OFS];
         end
      end

      // receive pins: two-stage sync, then optional filter
      next.rx_meta = rx_pin;
      next.rx_sync = s.rx_meta;
      next.rx_prev = s.rx_sync;
      for (int p = 0; p < 4; p++) begin
         if (!s.nfen[`FILT_STEP*p]) begin
            next.rx_filt[p] = s.rx_sync[p];
         end else if (s.rx_sync[p] == s.rx_prev[p]) begin
            // a one-clock glitch never reaches the output
            next.rx_filt[p] = s.rx_sync[p];
         end
      end

      // input switch for the lin wakeup and break timing
      next.irq_meta = ext_irq0_pin;
      next.irq_sync = s.irq_meta;
      next.tim_meta = timer_ch7_pin;
      next.tim_sync = s.tim_meta;
      next.irq_out  = s.route_sel[`ROUTE_IRQ] ? s.rx_filt[`RX_ROUTED]
                                              : s.irq_sync;
      next.tim_out  = s.route_sel[`ROUTE_TIM] ? s.rx_filt[`RX_ROUTED]
                                              : s.tim_sync;
   end

   ////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s             <= '0;
         s.waitrequest <= 1'h1;
         s.so          <= {`SO_RESET, `SO_RESET};
         s.gate        <= {`REG16_ZERO, `REG16_ZERO};
         s.inv         <= {`REG16_ZERO, `REG16_ZERO};
         s.nfen        <= `REG8_ZERO;
         s.route_sel   <= `REG8_ZERO;
         s.rx_meta     <= `RX_IDLE;
         s.rx_sync     <= `RX_IDLE;
         s.rx_prev     <= `RX_IDLE;
         s.rx_filt     <= `RX_IDLE;
         s.data_out    <= `PIN_IDLE;
         s.clk_out     <= `PIN_IDLE;
      end else begin
         s <= next;
      end
   end

   // outputs straight from the state register
   assign avm_resp.readdata    = {16'h0000, s.readdata};
   assign avm_resp.waitrequest = s.waitrequest;
   assign ser_data_out         = s.data_out;
   assign ser_clk_out          = s.clk_out;
   assign chan_run_status      = s.run;
   assign xfer_active_flag     = s.xfer;
   assign buf_full_flag        = s.buf_full;
   assign rx_filtered          = s.rx_filt;
   assign ext_irq0_input       = s.irq_out;
   assign timer_ch7_input_pin  = s.tim_out;

   ////////////////////////////////////////////////////////////
   // checks on channels 00 and 02, the fixed buffer bits of both units and the receive pins
   default clocking cb @(posedge clk);
   endclocking

   sequence halt_write_ch0;
      wr_take && idx == `IDX_HALT0 && avm_req.byteenable[0]
      && avm_req.writedata[0];
   endsequence

   sequence filt_settled;
      $past(s.nfen[6]) && $changed(s.rx_filt[3]);
   endsequence

   a_halt_stops_run: assert property (disable iff (rst)
      halt_write_ch0 |=> ##1 !s.run[0])
      else $error("halt write did not stop channel");

   a_halt_clears_flags: assert property (disable iff (rst)
      (s.halt_trig[0] && !eng_xfer_set[0] && !eng_buf_set[0])
      |=> !s.xfer[0] && !s.buf_full[0])
      else $error("halt left status flags set");

   a_halt_reads_zero: assert property (disable iff (rst)
      (avm_req.read && !s.waitrequest
       && idx == `IDX_HALT0) |-> avm_resp.readdata == 32'h0)
      else $error("halt register read not zero");

   a_gate_data_follow: assert property (disable iff (rst)
      s.gate[0][0] |=> s.so[0][0] == $past(eng_data_out[0]))
      else $error("gated data bit not from engine");

   a_pin_plain_data: assert property (disable iff (rst)
      !s.gate[0][0] |=> ser_data_out[0] == $past(s.so[0][0]))
      else $error("ungated pin differs from data bit");

   a_clock_pin_map: assert property (disable iff (rst)
      1'h1 |=> ser_clk_out[2] == $past(s.so[0][10]))
      else $error("clock pin not from bit n plus 8");

   a_clock_bit_locked: assert property (disable iff (rst)
      s.run[0] |=> s.so[0][8] == $past(eng_clk_out[0]))
      else $error("clock bit changed while running");

   a_buffer_reset: assert property (
      rst |=> s.so[0] == `SO_RESET && s.so[1] == `SO_RESET)
      else $error("output buffer reset value wrong");

   a_invert_gated: assert property (disable iff (rst)
      (s.gate[0][2] && s.inv[0][2])
      |=> ser_data_out[2] != $past(s.so[0][2]))
      else $error("inversion missing on gated pin");

   a_filter_two_match: assert property (disable iff (rst)
      filt_settled |-> $past(s.rx_sync[3]) == s.rx_filt[3]
                       && $past(s.rx_prev[3]) == s.rx_filt[3])
      else $error("filter passed an unconfirmed level");

   a_route_irq0: assert property (disable iff (rst)
      s.route_sel[`ROUTE_IRQ] |=> ext_irq0_input == $past(s.rx_filt[3]))
      else $error("irq0 not routed from receive pin");

   a_route_timer: assert property (disable iff (rst)
      s.route_sel[`ROUTE_TIM] |=> timer_ch7_input_pin == $past(s.rx_filt[3]))
      else $error("timer7 not routed from receive pin");

   a_go_sets_run: assert property (disable iff (rst)
      (s.go_trig[0] && !s.halt_trig[0]) |=> s.run[0])
      else $error("go trigger did not start channel");

   a_halt_self_clear: assert property (disable iff (rst)
      (s.halt_trig[0] && !s.run[0] && !wr_take) |=> !s.halt_trig[0])
      else $error("halt trigger did not self-clear");

   a_go_self_clear: assert property (disable iff (rst)
      (s.go_trig[0] && s.run[0] && !wr_take) |=> !s.go_trig[0])
      else $error("go trigger did not self-clear");

   // plain pins must pass untouched when the switch is off
   a_route_irq_plain: assert property (disable iff (rst)
      !s.route_sel[`ROUTE_IRQ] |=> ext_irq0_input == $past(s.irq_sync))
      else $error("irq0 not from its own pin");

   a_route_tim_plain: assert property (disable iff (rst)
      !s.route_sel[`ROUTE_TIM] |=> timer_ch7_input_pin == $past(s.tim_sync))
      else $error("timer7 not from its own pin");

   a_filter_off_pass: assert property (disable iff (rst)
      !s.nfen[0] |=> rx_filtered[0] == $past(s.rx_sync[0]))
      else $error("unfiltered pin not passed straight");

   // inversion left set on a closed gate must not reach the pin
   a_invert_needs_gate: assert property (disable iff (rst)
      (!s.gate[0][0] && s.inv[0][0]) |=> ser_data_out[0] == $past(s.so[0][0]))
      else $error("inversion applied with gate closed");

   a_fixed_buffer_bits: assert property (disable iff (rst)
      1'h1 |-> (s.so[0] & ~`BUF0_WMASK) == `BUF0_FIX1
               && (s.so[1] & ~`BUF1_WMASK) == `BUF1_FIX1)
      else $error("fixed buffer bits changed");
endmodule

/* File: verification/serial_peer_model.sv */
// far-side serial peer: drives the receive lines and plain input pins
// assumes its tasks are called right after a rising clk edge
`timescale 1ns/1ps
module serial_peer_model (
   input  wire logic clk,
   output logic [3:0] rx_pin,
   output logic       ext_irq0_pin,
   output logic       timer_ch7_pin
);
   ////////////////////////////////////////////////////////////
   // receive lines idle high, as a released uart line does
   initial begin
      rx_pin        = 4'hF;
      ext_irq0_pin  = 1'b0;
      timer_ch7_pin = 1'b0;
   end
   // low pulse on one receive line, length in clocks; one-clock
   // pulses model line noise that the filter must swallow
   task automatic pulse_low(input int ch, input int len);
      rx_pin[ch] <= 1'b0;
      repeat (len) @(posedge clk);
      rx_pin[ch] <= 1'b1;
   endtask
   // levels on the normal irq and timer pins
   task automatic set_plain(input logic irq_lvl, input logic tim_lvl);
      ext_irq0_pin  <= irq_lvl;
      timer_ch7_pin <= tim_lvl;
   endtask
endmodule

/* File: verification/serial_pin_output_control_tb_top.sv */
// self-checking bench for the pin output control block
// assumes package, header, design and peer model compiled first
`timescale 1ns/1ps
`include "serial_pin_out_cfg.svh"
module serial_pin_output_control_tb_top;
   import serial_pin_pkg::*;
   logic         clk, rst, irq_pin, tim_pin, irq_in, tim_in;
   avm_req_type  req;
   avm_resp_type resp;
   logic [7:0]   eng_data, eng_clk, xfer_set, buf_set;
   logic [7:0]   data_pins, clk_pins, run, xfer, bfull;
   logic [3:0]   rx_pin, rx_filt;
   logic [31:0]  lfsr;
   logic [15:0]  rd, v, e;
   int           failures, n_compared, cnt;
   // register table: index, reset, writable bits, bits fixed at one
   logic [19:0]  idx_t [8] = '{`IDX_NFEN, `IDX_BUF0, `IDX_GATE0, `IDX_INV0,
                               `IDX_BUF1, `IDX_GATE1, `IDX_INV1, `IDX_ROUTE};
   logic [15:0]  rst_t [8] = '{16'h0000, 16'h0F0F, 16'h0000, 16'h0000,
                               16'h0F0F, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0]  msk_t [8] = '{16'h0055, 16'h0505, 16'h0005, 16'h0005,
                               16'h0105, 16'h0005, 16'h0005, 16'h001F};
   logic [15:0]  one_t [8] = '{16'h0000, 16'h0A0A, 16'h0000, 16'h0000,
                               16'h0E0A, 16'h0000, 16'h0000, 16'h0000};
   serial_pin_output_control dut_u (
      .clk                 (clk),
      .rst                 (rst),
      .avm_req             (req),
      .avm_resp            (resp),
      .eng_data_out        (eng_data),
      .eng_clk_out         (eng_clk),
      .eng_xfer_set        (xfer_set),
      .eng_buf_set         (buf_set),
      .rx_pin              (rx_pin),
      .ext_irq0_pin        (irq_pin),
      .timer_ch7_pin       (tim_pin),
      .ser_data_out        (data_pins),
      .ser_clk_out         (clk_pins),
      .chan_run_status     (run),
      .xfer_active_flag    (xfer),
      .buf_full_flag       (bfull),
      .rx_filtered         (rx_filt),
      .ext_irq0_input      (irq_in),
      .timer_ch7_input_pin (tim_in)
   );
   serial_peer_model peer_u (
      .clk           (clk),
      .rx_pin        (rx_pin),
      .ext_irq0_pin  (irq_pin),
      .timer_ch7_pin (tim_pin)
   );
   ////////////////////////////////////////////////////////////
   always #12.5 clk = ~clk;
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[15:0];
   endfunction
   // expected readback of a register after writing wd
   function automatic logic [15:0] reg_exp(input int i, input logic [15:0] wd);
      return (wd & msk_t[i]) | one_t[i];
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one access; the request holds until waitrequest is sampled low,
   // then a spare edge so no strobe is dropped and raised in one step
   task automatic bus(input logic wr, input logic [19:0] idx, input logic [15:0] wd);
      int n;
      n = 0;
      req.address   <= {idx, 2'b00};
      req.writedata <= {16'h0000, wd};
      req.write     <= wr;
      req.read      <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (resp.waitrequest !== 1'b0 && n < 40);
      rd = resp.readdata[15:0];
      req.write <= 1'b0;
      req.read  <= 1'b0;
      if (n >= 40) begin
         failures++;
         tally_and_finish();
      end
      @(posedge clk);
   endtask
   task automatic rdchk(input string what, input logic [19:0] idx, input logic [15:0] exp);
      bus(1'b0, idx, 16'h0000);
      chk(what, rd, exp);
   endtask
   // low pulse on a receive line, then count low cycles at the filter
   task automatic glitch(input int ch, input int len);
      peer_u.pulse_low(ch, len);
      cnt = 0;
      repeat (10) begin
         @(posedge clk);
         if (rx_filt[ch] !== 1'b1) cnt++;
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      req = '{1'b0, 1'b0, 22'h0, 32'h0, 4'hF};
      eng_data = 8'h00;
      eng_clk = 8'hFF;
      xfer_set = 8'h00;
      buf_set = 8'h00;
      failures = 0;
      n_compared = 0;
      lfsr = 32'hE81F;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values, random writes through the fixed-bit masks
      chk("pins", {data_pins, clk_pins}, 16'hFFFF);
      chk("rx levels", {12'h000, rx_filt}, 16'h000F);
      for (int i = 0; i < 8; i++) begin
         rdchk("reset value", idx_t[i], rst_t[i]);
         v = rnd();
         // buffer writes keep the fixed bits as software must
         if (i == 1 || i == 4) v = (v & msk_t[i]) | one_t[i];
         e = reg_exp(i, v);
         bus(1'b1, idx_t[i], v);
         rdchk("masked write", idx_t[i], e);
         if (i == 1 || i == 4) begin
            chk("data pins", {12'h000, data_pins[i/4*4 +: 4]}, {12'h000, e[3:0]});
            chk("clock pins", {12'h000, clk_pins[i/4*4 +: 4]}, {12'h000, e[11:8]});
         end
      end
      for (int i = 7; i >= 0; i--) bus(1'b1, idx_t[i], rst_t[i]);
      bus(1'b1, 20'hF0200, 16'hFFFF);
      rdchk("unmapped", 20'hF0200, 16'h0000);
      $display("test registers done");
      // gated channels follow the engine, channel 0 inverted
      bus(1'b1, `IDX_GATE0, 16'h0005);
      bus(1'b1, `IDX_INV0, 16'h0001);
      repeat (4) begin
         v = rnd();
         eng_data <= v[7:0];
         bus(1'b1, `IDX_BUF0, {12'h0F0, 1'b1, ~v[2], 1'b1, ~v[0]});
         rdchk("gated data", `IDX_BUF0, {12'h0F0, 1'b1, v[2], 1'b1, v[0]});
         chk("inverted pin", {15'h0000, data_pins[0]}, {15'h0000, ~v[0]});
         chk("plain pin", {15'h0000, data_pins[2]}, {15'h0000, v[2]});
      end
      bus(1'b1, `IDX_GATE0, 16'h0000);
      bus(1'b1, `IDX_BUF0, 16'h0F0E);
      rdchk("ungated data", `IDX_BUF0, 16'h0F0E);
      chk("uninverted pin", {15'h0000, data_pins[0]}, 16'h0000);
      bus(1'b1, `IDX_INV0, 16'h0000);
      $display("test gating done");
      // start, flags, halt, and the clock bit lock while running
      eng_clk <= 8'hFE;
      bus(1'b1, `IDX_GO0, 16'h0001);
      rdchk("run status", `IDX_RUN0, 16'h0001);
      rdchk("go reads", `IDX_GO0, 16'h0000);
      bus(1'b1, `IDX_BUF0, 16'h0F0E);
      rdchk("running clock", `IDX_BUF0, 16'h0E0E);
      chk("clock pin", {15'h0000, clk_pins[0]}, 16'h0000);
      xfer_set <= 8'h01;
      buf_set  <= 8'h01;
      @(posedge clk);
      xfer_set <= 8'h00;
      buf_set  <= 8'h00;
      repeat (2) @(posedge clk);
      chk("flags set", {xfer, bfull}, 16'h0101);
      bus(1'b1, `IDX_HALT0, 16'h0001);
      rdchk("halt reads", `IDX_HALT0, 16'h0000);
      eng_clk <= 8'hFF;
      chk("halted", {run, xfer}, 16'h0000);
      chk("buffer flag", {8'h00, bfull}, 16'h0000);
      rdchk("kept pins", `IDX_BUF0, 16'h0E0E);
      bus(1'b1, `IDX_BUF0, 16'h0F0F);
      rdchk("stopped clock", `IDX_BUF0, 16'h0F0F);
      $display("test run control done");
      // input switch: plain pins, then the receive line in their place
      peer_u.set_plain(1'b1, 1'b0);
      repeat (6) @(posedge clk);
      chk("plain routes", {14'h0000, irq_in, tim_in}, 16'h0002);
      bus(1'b1, `IDX_ROUTE, 16'h0003);
      peer_u.set_plain(1'b1, 1'b1);
      peer_u.pulse_low(3, 8);
      chk("rx routed", {14'h0000, irq_in, tim_in}, 16'h0000);
      repeat (6) @(posedge clk);
      chk("rx released", {14'h0000, irq_in, tim_in}, 16'h0003);
      bus(1'b1, `IDX_ROUTE, 16'h0000);
      $display("test routing done");
      // each filter swallows a one-clock glitch, passes two clocks
      for (int ch = 0; ch < 4; ch++) begin
         bus(1'b1, `IDX_NFEN, 16'h0001 << (2 * ch));
         glitch(ch, 1);
         chk("filtered glitch", cnt[15:0], 16'h0000);
         glitch(ch, 2);
         chk("two-clock level", {15'h0000, cnt != 0}, 16'h0001);
         bus(1'b1, `IDX_NFEN, 16'h0000);
         glitch(ch, 1);
         chk("unfiltered glitch", cnt[15:0], 16'h0001);
      end
      $display("test filter done");
      tally_and_finish();
   end
endmodule
